// ---- logic/cstr_pkg.sv ----
/*
 * Constants for the capacitive sense tuning and touch release block:
 * register map, field positions, reset values and tuning figures.
 * Assumes a single 200 MHz clock and a 32-bit APB register bus.
 */
package cstr_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_THRESH   = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;
   localparam logic [7:0] ADDR_COUNT    = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   // ----------------------------------------------------------------
   // Control fields and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_BASE_LSB   = 0;
   localparam int CTRL_TARGET_BIT = 3;
   localparam int CTRL_REL_BIT    = 6;
   localparam int CTRL_AUX_DIR    = 7;
   localparam int CTRL_MAIN_SRC   = 8;
   localparam int CTRL_AUX_FUNC   = 9;
   localparam int CTRL_RETUNE     = 10;
   localparam int CTRL_W          = 10;
   localparam logic [9:0]  CTRL_RESET   = 10'h000;
   localparam logic [15:0] THRESH_RESET = 16'h1008;

   // Interrupt bit positions
   localparam int IRQ_PROX  = 0;
   localparam int IRQ_ENTER = 1;
   localparam int IRQ_LEAVE = 2;
   localparam int IRQ_TUNED = 3;
   localparam int IRQ_W     = 4;

   // ----------------------------------------------------------------
   // Tuning figures
   // ----------------------------------------------------------------
   localparam int CNT_W  = 16;
   localparam int MULT_W = 6;
   localparam int COMP_W = 8;
   localparam logic [15:0] TARGET_HI   = 16'h04B0;
   localparam logic [15:0] TARGET_LO   = 16'h0400;
   localparam logic [15:0] RETUNE_BAND = 16'h0100;
   localparam logic [15:0] NEAR_WINDOW = 16'h0010;
   localparam int LTA_SHIFT = 4;

   // Base values 200,50,75,100,150,250,300,500 indexed by select code
   localparam logic [15:0] BASE_TAB [8] = '{16'h00C8, 16'h0032, 16'h004B, 16'h0064,
                                            16'h0096, 16'h00FA, 16'h012C, 16'h01F4};

   function automatic logic [15:0] base_value(input logic [2:0] sel);
      base_value = BASE_TAB[sel];
   endfunction : base_value

   function automatic logic [15:0] target_value(input logic sel);
      target_value = sel ? TARGET_LO : TARGET_HI;
   endfunction : target_value

   typedef enum logic [1:0] {TUNE_IDLE, TUNE_COARSE, TUNE_FINE} cstr_tune_state_t;

endpackage : cstr_pkg

// ---- logic/cstr_top.sv ----
/*
 * Capacitive sense control: tuning start, long-term average filter,
 * proximity and touch detection, touch-mode release, auxiliary pin,
 * APB registers and interrupt.
 * Assumes the sample count arrives on i_mclk with a one-cycle valid;
 * the auxiliary pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module cstr_top
(
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_sample_valid,
   input  wire logic [15:0] i_sample_count,
   output logic [5:0]       o_tune_mult,
   output logic [7:0]       o_tune_comp,
   output logic             o_tune_busy,
   output logic             o_main_out,
   input  wire logic        i_aux_in,
   output logic             o_aux_out,
   output logic             o_aux_oe,
   output logic             o_charge_halt,
   output logic             o_irq
);

   cstr_tune_if tif ();

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [9:0]  ctrl_q;
   logic [15:0] thresh_q;
   logic [3:0]  irq_stat_q;
   logic [3:0]  irq_mask_q;
   logic        boot_q;
   logic        retune_q;
   logic [15:0] count_q;
   logic [15:0] lta_q;
   logic        lta_seeded_q;
   logic        prox_q;
   logic        touch_q;
   logic        tmode_q;
   logic [15:0] lta_entry_q;
   logic [15:0] entry_delta_q;
   logic        delta_ok_q;
   logic [1:0]  aux_sync_q;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        main_out_q;
   logic        aux_out_q;
   logic        aux_oe_q;
   logic        charge_halt_q;
   logic        irq_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire access_w  = i_psel && i_penable;
   wire wr_fire_w = access_w && pready_q && i_pwrite;
   wire sel_ctrl  = i_paddr == cstr_pkg::ADDR_CTRL;
   wire sel_thr   = i_paddr == cstr_pkg::ADDR_THRESH;
   wire sel_stat  = i_paddr == cstr_pkg::ADDR_STATUS;
   wire sel_cnt   = i_paddr == cstr_pkg::ADDR_COUNT;
   wire sel_istat = i_paddr == cstr_pkg::ADDR_IRQ_STAT;
   wire sel_imask = i_paddr == cstr_pkg::ADDR_IRQ_MASK;
   wire mapped_w  = sel_ctrl | sel_thr | sel_stat | sel_cnt | sel_istat | sel_imask;
   wire retune_wr = wr_fire_w && sel_ctrl && i_pwdata[cstr_pkg::CTRL_RETUNE];

   // ----------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------
   wire [2:0]  base_sel_w   = ctrl_q[cstr_pkg::CTRL_BASE_LSB +: 3];
   wire        target_sel_w = ctrl_q[cstr_pkg::CTRL_TARGET_BIT];
   wire        rel_sel_w    = ctrl_q[cstr_pkg::CTRL_REL_BIT];
   wire        aux_is_in_w  = ctrl_q[cstr_pkg::CTRL_AUX_DIR];
   wire        main_touch_w = ctrl_q[cstr_pkg::CTRL_MAIN_SRC];
   wire        aux_chg_w    = ctrl_q[cstr_pkg::CTRL_AUX_FUNC];
   wire [15:0] prox_thr_w   = {8'h00, thresh_q[7:0]};
   wire [15:0] touch_thr_w  = {8'h00, thresh_q[15:8]};
   wire [15:0] target_w     = cstr_pkg::target_value(target_sel_w);
   wire [15:0] base_w       = cstr_pkg::base_value(base_sel_w);
   wire [7:0]  sens_w       = 8'(target_w / base_w);

   // ----------------------------------------------------------------
   // Detection arithmetic
   // ----------------------------------------------------------------
   wire        busy_w    = tif.busy;
   wire        below_w   = lta_q >= count_q;
   wire [15:0] drop_w    = below_w ? lta_q - count_q : 16'h0000;
   wire [15:0] gap_w     = below_w ? lta_q - count_q : count_q - lta_q;
   wire        near_w    = gap_w <= cstr_pkg::NEAR_WINDOW;
   wire        prox_w    = lta_seeded_q && !busy_w && drop_w > prox_thr_w;
   wire        touch_w   = lta_seeded_q && !busy_w && drop_w > touch_thr_w;
   wire [16:0] lo_band_w = {1'b0, target_w} - {1'b0, cstr_pkg::RETUNE_BAND};
   wire [16:0] hi_band_w = {1'b0, target_w} + {1'b0, cstr_pkg::RETUNE_BAND};
   wire        out_rng_w = {1'b0, count_q} < lo_band_w || {1'b0, count_q} > hi_band_w;

   // Release threshold: 3/4 or 7/8 of the entry delta
   wire [15:0] rel_34_w  = (entry_delta_q >> 1) + (entry_delta_q >> 2);
   wire [15:0] rel_78_w  = rel_34_w + (entry_delta_q >> 3);
   wire [15:0] rel_thr_w = rel_sel_w ? rel_78_w : rel_34_w;
   wire        leave_w   = tmode_q && delta_ok_q && drop_w < rel_thr_w;
   wire        enter_w   = !tmode_q && touch_w;

   // ----------------------------------------------------------------
   // Average filter control
   // ----------------------------------------------------------------
   wire aux_lvl_w    = aux_sync_q[1];
   wire ext_fhalt_w  = aux_is_in_w && !aux_chg_w && aux_lvl_w;
   wire ext_chalt_w  = aux_is_in_w && aux_chg_w && aux_lvl_w;
   wire freeze_w     = (prox_q && !touch_q && !tmode_q) || ext_fhalt_w;
   wire [15:0] step_w = (gap_w >> cstr_pkg::LTA_SHIFT) | {15'h0000, |gap_w};
   wire lta_step_w   = lta_seeded_q && i_sample_valid && !busy_w && !freeze_w;

   // ----------------------------------------------------------------
   // Tuning engine link
   // ----------------------------------------------------------------
   assign tif.start        = boot_q || retune_q;
   assign tif.base_sel     = base_sel_w;
   assign tif.target_sel   = target_sel_w;
   assign tif.sample_valid = i_sample_valid;
   assign tif.count        = i_sample_count;

   cstr_tuner u_tuner
   (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .tif       (tif)
   );

   // ----------------------------------------------------------------
   // Start-up and retune requests
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         boot_q   <= 1'b1;
         retune_q <= 1'b0;
      end
      else
      begin
         boot_q   <= 1'b0;
         // Software request, a large drop, or an out-of-range count before seeding
         retune_q <= !busy_w && !retune_q && (retune_wr ||
                     (lta_seeded_q && i_sample_valid && !tmode_q &&
                      {1'b0, i_sample_count} < lo_band_w) ||
                     (!lta_seeded_q && i_sample_valid && out_rng_w && tif.mult != 6'h00));
      end
   end

   // ----------------------------------------------------------------
   // Sample capture and long-term average
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         count_q      <= 16'h0000;
         lta_q        <= 16'h0000;
         lta_seeded_q <= 1'b0;
      end
      else
      begin
         if (i_sample_valid)
            count_q <= i_sample_count;
         if (busy_w)
            lta_seeded_q <= 1'b0;
         // Done shows one edge after the final sample, when the count line is stale
         else if (tif.done)
         begin
            lta_q        <= count_q;
            lta_seeded_q <= 1'b1;
         end
         else if (!lta_seeded_q && i_sample_valid)
         begin
            lta_q        <= i_sample_count;
            lta_seeded_q <= 1'b1;
         end
         else if (lta_step_w)
            lta_q <= below_w ? lta_q - step_w : lta_q + step_w;
      end
   end

   // ----------------------------------------------------------------
   // Detection and touch mode
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         prox_q        <= 1'b0;
         touch_q       <= 1'b0;
         tmode_q       <= 1'b0;
         lta_entry_q   <= 16'h0000;
         entry_delta_q <= 16'h0000;
         delta_ok_q    <= 1'b0;
      end
      else
      begin
         prox_q  <= prox_w;
         touch_q <= touch_w;
         if (busy_w)
         begin
            tmode_q    <= 1'b0;
            delta_ok_q <= 1'b0;
         end
         else if (enter_w)
         begin
            tmode_q     <= 1'b1;
            lta_entry_q <= lta_q;
            if (near_w)
            begin
               entry_delta_q <= touch_thr_w;
               delta_ok_q    <= 1'b1;
            end
            else
               delta_ok_q <= 1'b0;
         end
         else if (leave_w)
         begin
            tmode_q    <= 1'b0;
            delta_ok_q <= 1'b0;
         end
         // Average has tracked to within the window: fix the entry delta
         else if (tmode_q && !delta_ok_q && near_w)
         begin
            entry_delta_q <= lta_entry_q - lta_q;
            delta_ok_q    <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         aux_sync_q    <= 2'b00;
         main_out_q    <= 1'b0;
         aux_out_q     <= 1'b0;
         aux_oe_q      <= 1'b0;
         charge_halt_q <= 1'b0;
      end
      else
      begin
         aux_sync_q    <= {aux_sync_q[0], i_aux_in};
         main_out_q    <= main_touch_w ? tmode_q : (prox_q || tmode_q);
         aux_oe_q      <= !aux_is_in_w;
         aux_out_q     <= !aux_is_in_w && prox_q;
         charge_halt_q <= ext_chalt_w;
      end
   end

   // ----------------------------------------------------------------
   // Register writes and interrupt
   // ----------------------------------------------------------------
   wire [3:0] irq_set_w;
   wire [3:0] irq_clr_w;
   assign irq_set_w[cstr_pkg::IRQ_PROX]  = prox_w && !prox_q;
   assign irq_set_w[cstr_pkg::IRQ_ENTER] = enter_w && !busy_w;
   assign irq_set_w[cstr_pkg::IRQ_LEAVE] = leave_w && !busy_w && !enter_w;
   assign irq_set_w[cstr_pkg::IRQ_TUNED] = tif.done;
   assign irq_clr_w = (wr_fire_w && sel_istat) ? i_pwdata[3:0] : 4'h0;

   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctrl_q     <= cstr_pkg::CTRL_RESET;
         thresh_q   <= cstr_pkg::THRESH_RESET;
         irq_mask_q <= 4'h0;
         irq_stat_q <= 4'h0;
         irq_q      <= 1'b0;
      end
      else
      begin
         if (wr_fire_w && sel_ctrl)
            ctrl_q <= i_pwdata[9:0];
         if (wr_fire_w && sel_thr)
            thresh_q <= i_pwdata[15:0];
         if (wr_fire_w && sel_imask)
            irq_mask_q <= i_pwdata[3:0];
         irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_set_w;
         irq_q      <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Read path: one wait state, data from a register
   // ----------------------------------------------------------------
   wire [31:0] status_w = {tif.comp, 2'b00, tif.mult, sens_w,
                           3'b000, delta_ok_q, tmode_q, touch_q, prox_q, busy_w};
   wire [31:0] rd_mux_w = sel_ctrl  ? {22'h000000, ctrl_q} :
                          sel_thr   ? {16'h0000, thresh_q} :
                          sel_stat  ? status_w :
                          sel_cnt   ? {lta_q, count_q} :
                          sel_istat ? {28'h0000000, irq_stat_q} :
                          sel_imask ? {28'h0000000, irq_mask_q} : 32'h00000000;

   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= access_w && !pready_q;
         pslverr_q <= access_w && !pready_q && !mapped_w;
         if (access_w && !pready_q && !i_pwrite)
            prdata_q <= rd_mux_w;
      end
   end

   assign o_prdata      = prdata_q;
   assign o_pready      = pready_q;
   assign o_pslverr     = pslverr_q;
   assign o_tune_mult   = tif.mult;
   assign o_tune_comp   = tif.comp;
   assign o_tune_busy   = tif.busy;
   assign o_main_out    = main_out_q;
   assign o_aux_out     = aux_out_q;
   assign o_aux_oe      = aux_oe_q;
   assign o_charge_halt = charge_halt_q;
   assign o_irq         = irq_q;

endmodule : cstr_top
`default_nettype wire

// ---- logic/cstr_tune_if.sv ----
/*
 * Carrier between the touch/release top and the tuning engine.
 * Assumes both ends share the one system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface cstr_tune_if;
   logic        start;
   logic [2:0]  base_sel;
   logic        target_sel;
   logic        sample_valid;
   logic [15:0] count;
   logic        busy;
   logic        done;
   logic [5:0]  mult;
   logic [7:0]  comp;
   modport tuner (input start, base_sel, target_sel, sample_valid, count,
                  output busy, done, mult, comp);
   modport ctrl  (output start, base_sel, target_sel, sample_valid, count,
                  input busy, done, mult, comp);
endinterface : cstr_tune_if
`default_nettype wire

// ---- logic/cstr_tuner.sv ----
/*
 * Automatic tuning engine: coarse multiplier search to the base value,
 * then compensation steps until the count equals the target or the compensation reaches its end.
 * Assumes each sample reflects the settings of the previous step.
 */
`timescale 1ns/1ps
`default_nettype none
module cstr_tuner
(
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   cstr_tune_if.tuner       tif
);

   cstr_pkg::cstr_tune_state_t state_q;
   logic [15:0]                base_w;
   logic [15:0]                target_w;
   logic                       mult_max_w;
   logic                       comp_max_w;
   logic                       comp_min_w;

   assign base_w     = cstr_pkg::base_value(tif.base_sel);
   assign target_w   = cstr_pkg::target_value(tif.target_sel);
   assign mult_max_w = &tif.mult;
   assign comp_max_w = &tif.comp;
   assign comp_min_w = ~|tif.comp;

   // ----------------------------------------------------------------
   // Search sequence
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q  <= cstr_pkg::TUNE_IDLE;
         tif.busy <= 1'b0;
         tif.done <= 1'b0;
         tif.mult <= 6'h00;
         tif.comp <= 8'h00;
      end
      else
      begin
         tif.done <= 1'b0;
         case (state_q)
            cstr_pkg::TUNE_IDLE:
               if (tif.start)
               begin
                  state_q  <= cstr_pkg::TUNE_COARSE;
                  tif.busy <= 1'b1;
                  tif.mult <= 6'h00;
                  tif.comp <= 8'h00;
               end
            cstr_pkg::TUNE_COARSE:
               if (tif.sample_valid)
               begin
                  if (tif.count < base_w && !mult_max_w)
                     tif.mult <= tif.mult + 6'h01;
                  else
                     state_q <= cstr_pkg::TUNE_FINE;
               end
            cstr_pkg::TUNE_FINE:
               if (tif.sample_valid)
               begin
                  if (tif.count == target_w || (tif.count < target_w && comp_max_w)
                      || (tif.count > target_w && comp_min_w))
                  begin
                     state_q  <= cstr_pkg::TUNE_IDLE;
                     tif.busy <= 1'b0;
                     tif.done <= 1'b1;
                  end
                  else if (tif.count < target_w)
                     tif.comp <= tif.comp + 8'h01;
                  else
                     tif.comp <= tif.comp - 8'h01;
               end
            default:
               state_q <= cstr_pkg::TUNE_IDLE;
         endcase
      end
   end

endmodule : cstr_tuner
`default_nettype wire

// ---- sim/cstr_sense_model.sv ----
/*
 * Electrode model: count is 40 per multiplier step plus 8 per
 * compensation step, less the finger drop; a sample every 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module cstr_sense_model
(
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   input  wire logic [5:0]  i_mult,
   input  wire logic [7:0]  i_comp,
   input  wire logic [15:0] i_drop,
   output logic             o_valid,
   output logic [15:0]      o_count
);
   logic [1:0]  div_q;
   logic [15:0] level;
   assign level = 16'(i_mult) * 16'h0028 + 16'(i_comp) * 16'h0008 - i_drop;
   // Between samples the line carries junk, not the last count
   assign o_count = o_valid ? level : ~level;
   assign o_valid = (div_q == 2'h3);
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end
endmodule : cstr_sense_model
`default_nettype wire

// ---- sim/cstr_sva.sv ----
/*
 * Port checker for cstr_top: bus timing, tuning steps, aux pin.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module cstr_sva
(
   input wire logic       i_mclk,
   input wire logic       i_sys_rst,
   input wire logic       i_psel,
   input wire logic       i_penable,
   input wire logic       o_pready,
   input wire logic       o_pslverr,
   input wire logic [5:0] o_tune_mult,
   input wire logic [7:0] o_tune_comp,
   input wire logic       o_tune_busy,
   input wire logic       o_main_out,
   input wire logic       o_aux_out,
   input wire logic       o_aux_oe,
   input wire logic       o_charge_halt
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_setup;
      i_psel && !i_penable ##1 i_psel && i_penable;
   endsequence
   sequence s_tuning;
      o_tune_busy [*2];
   endsequence
   AST_START: assert property ($fell(i_sys_rst) |-> ##[1:3] o_tune_busy)
      else $error("tuning did not start");
   AST_WAIT: assert property (s_setup |=> o_pready)
      else $error("no ready after one wait state");
   AST_PULSE: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   AST_ERR: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   AST_QUIET: assert property (o_tune_busy [*3] |-> !o_main_out && !o_aux_out)
      else $error("detection while tuning");
   AST_AUXIN: assert property (!o_aux_oe |-> !o_aux_out)
      else $error("aux driven while input");
   AST_NOHALT: assert property (o_aux_oe [*2] |-> !o_charge_halt)
      else $error("charge halt while aux is output");
   AST_HOLD: assert property (!o_tune_busy [*2] |-> $stable(o_tune_mult) && $stable(o_tune_comp))
      else $error("settings moved while idle");
   AST_MSTEP: assert property (s_tuning ##0 $changed(o_tune_mult) |-> o_tune_mult == $past(o_tune_mult) + 6'h01)
      else $error("multiplier step not one up");
   AST_CSTEP: assert property (s_tuning ##0 $changed(o_tune_comp)
      |-> 8'(o_tune_comp - $past(o_tune_comp)) inside {8'h01, 8'hFF})
      else $error("compensation step not one");
endmodule : cstr_sva
bind cstr_top cstr_sva cstr_sva_inst (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .o_pready, .o_pslverr,
   .o_tune_mult, .o_tune_comp, .o_tune_busy, .o_main_out, .o_aux_out, .o_aux_oe, .o_charge_halt);
`default_nettype wire

// ---- sim/cstr_top_tb.sv ----
/*
 * Testbench for cstr_top: registers, tuning, aux pin, touch.
 * Assumes the electrode model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module cstr_top_tb;
   logic        i_mclk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_psel = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite = 1'b0;
   logic        i_aux_in = 1'b0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [15:0] drop = 16'h0;
   logic [31:0] o_prdata, rd;
   logic [15:0] i_sample_count;
   logic [7:0]  o_tune_comp;
   logic [5:0]  o_tune_mult;
   logic        o_pready, o_pslverr, i_sample_valid, o_tune_busy, o_main_out;
   logic        o_aux_out, o_aux_oe, o_charge_halt, o_irq, er;
   logic [3:0]  mon;
   int          num_errors = 0;
   int          comparisons = 0;
   assign mon = {o_irq, o_aux_out, o_main_out, o_tune_busy};
   always #2.5 i_mclk = ~i_mclk;
   cstr_top cstr_top_inst (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_sample_valid, .i_sample_count, .o_tune_mult, .o_tune_comp,
      .o_tune_busy, .o_main_out, .i_aux_in, .o_aux_out, .o_aux_oe, .o_charge_halt, .o_irq);
   cstr_sense_model cstr_sense_model_inst (.i_mclk, .i_sys_rst, .i_mult(o_tune_mult), .i_comp(o_tune_comp),
      .i_drop(drop), .o_valid(i_sample_valid), .o_count(i_sample_count));
   task automatic complete_run();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_bit(input int b, input logic v, input int lim);
      int n;
      n = 0;
      while (mon[b] !== v && n < lim)
      begin
         @(posedge i_mclk);
         n++;
      end
      check(32'(mon[b]), 32'(v));
      if (mon[b] !== v)
         complete_run();
   endtask : wait_bit
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20)
      begin
         num_errors++;
         complete_run();
      end
   endtask : apb
   task automatic t_tune();
      apb(1'b0, cstr_pkg::ADDR_THRESH, 32'h0);
      check(rd, 32'h1008);
      apb(1'b1, 8'h18, 32'h0);
      check({31'h0, er}, 32'h1);
      wait_bit(0, 1'b0, 4000);
      check(32'({o_tune_mult, o_tune_comp}), 32'h57D);
      apb(1'b0, cstr_pkg::ADDR_IRQ_STAT, 32'h0);
      check(rd, 32'h8);
      apb(1'b1, cstr_pkg::ADDR_IRQ_MASK, 32'h8);
      wait_bit(3, 1'b1, 4);
      apb(1'b1, cstr_pkg::ADDR_IRQ_STAT, 32'h8);
      wait_bit(3, 1'b0, 4);
   endtask : t_tune
   task automatic t_bases();
      logic [15:0] base [8] = '{16'hC8, 16'h32, 16'h4B, 16'h64, 16'h96, 16'hFA, 16'h12C, 16'h1F4};
      logic [15:0] tgt, b, m;
      for (int s = 0; s < 9; s++)
      begin
         tgt = (s == 8) ? 16'h400 : 16'h4B0;
         b = base[s % 8];
         m = (b + 16'h27) / 16'h28;
         apb(1'b1, cstr_pkg::ADDR_CTRL, (s == 8) ? 32'h408 : 32'h400 + 32'(s));
         apb(1'b0, cstr_pkg::ADDR_STATUS, 32'h0);
         check(32'(rd[0]), 32'h1);
         wait_bit(0, 1'b0, 4000);
         check(32'(o_tune_mult), 32'(m));
         check(32'(o_tune_comp), 32'((tgt - m * 16'h28) / 16'h8));
         apb(1'b0, cstr_pkg::ADDR_STATUS, 32'h0);
         check(32'(rd[15:8]), 32'(tgt / b));
      end
   endtask : t_bases
   task automatic t_pins();
      apb(1'b1, cstr_pkg::ADDR_CTRL, 32'h288);
      i_aux_in <= 1'b1;
      repeat (6) @(posedge i_mclk);
      check(32'({o_aux_oe, o_charge_halt}), 32'h1);
      apb(1'b1, cstr_pkg::ADDR_CTRL, 32'h148);
      repeat (6) @(posedge i_mclk);
      check(32'({o_aux_oe, o_charge_halt}), 32'h2);
      drop <= 16'hC;
      wait_bit(2, 1'b1, 40);
      repeat (40) @(posedge i_mclk);
      check(32'({o_main_out, o_tune_busy}), 32'h0);
      drop <= 16'h64;
      wait_bit(1, 1'b1, 40);
      apb(1'b0, cstr_pkg::ADDR_STATUS, 32'h0);
      check(32'(rd[4:1]), 32'h7);
      repeat (400) @(posedge i_mclk);
      drop <= 16'h0;
      wait_bit(1, 1'b0, 400);
      apb(1'b0, cstr_pkg::ADDR_IRQ_STAT, 32'h0);
      check(32'(rd[2:1]), 32'h3);
   endtask : t_pins
   initial
   begin
      repeat (12) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      t_tune();
      t_bases();
      t_pins();
      complete_run();
   end
endmodule : cstr_top_tb
`default_nettype wire
